/* File: verilog/crld_ctrl_load.sv */
// control register load decoder with bus access to its registers
//
// Overview of operation
// - executing the first interrupt load copies the accumulator into interrupt register one.
// - word 03F is the first interrupt load, one word and one cycle long.
// - executing the second interrupt load copies the accumulator into interrupt register two.
// - word 03E is the second interrupt load, one word and one cycle long.
// - executing the first timer load copies the accumulator into timer register one.
// - executing the second timer load copies the accumulator into timer register two.
// - word 20F is the second timer load, one word and one cycle long.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "crld_params.svh"

module crld_ctrl_load
    import crld_pkg::*;
#(
    parameter logic [9:0] TMR_ONE_OP = `CRLD_OP_TMR_ONE_DEFAULT
) (
    input wire logic mclk, // instruction clock
    input wire logic reset, // synchronous reset, high
    input wire logic [9:0] instrWord, // word being executed
    input wire logic instrExec, // one cycle per executed word
    input wire logic [3:0] accValue, // accumulator contents
    input wire crld_axi_req_t axiReq, // bus request
    output crld_axi_rsp_t axiRsp, // bus answer
    output crld_ctrl_regs_t ctrlRegs, // the four control registers
    output logic loadDone // pulse after any load
);

    crld_state_t cur;
    crld_state_t next_cur;
    logic [3:0] hitVec;

    ////////////////////////////////////////////////////////////////////////
    // read mux, shared by the read path and nothing else written twice
    function automatic logic [31:0] readReg(input logic [7:0] addr, input crld_state_t s);
        logic [31:0] v;
        v = 32'h0;
        case (addr)
            `CRLD_OFS_CTRL: v = 32'h0;
            `CRLD_OFS_STATUS: begin
                v[`CRLD_STAT_SEEN_LSB +: 4] = s.seen;
                v[`CRLD_STAT_CNT_LSB +: 8] = s.loadCnt;
                v[`CRLD_STAT_LAST_LSB +: 2] = s.lastLoad;
            end
            `CRLD_OFS_INT_ONE: v[3:0] = s.regs.intCtrlRegOne;
            `CRLD_OFS_INT_TWO: v[3:0] = s.regs.intCtrlRegTwo;
            `CRLD_OFS_TMR_ONE: v[3:0] = s.regs.timerCtrlRegOne;
            `CRLD_OFS_TMR_TWO: v[3:0] = s.regs.timerCtrlRegTwo;
            default: v = 32'h0;
        endcase
        return v;
    endfunction : readReg

    function automatic logic addrMapped(input logic [7:0] addr);
        logic m;
        m = 1'b0;
        case (addr)
            `CRLD_OFS_CTRL, `CRLD_OFS_STATUS, `CRLD_OFS_INT_ONE,
            `CRLD_OFS_INT_TWO, `CRLD_OFS_TMR_ONE, `CRLD_OFS_TMR_TWO: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction : addrMapped

    ////////////////////////////////////////////////////////////////////////
    // opcode match
    crld_decode #(
        .TMR_ONE_OP(TMR_ONE_OP)
    ) u_decode (
        .instrWord(instrWord),
        .instrExec(instrExec),
        .hitVec(hitVec)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic doWrite;
        logic doRead;
        logic clrSeen;
        doWrite = 1'b0;
        doRead = 1'b0;
        clrSeen = 1'b0;
        next_cur = cur;
        next_cur.loadDone = |hitVec;

        // only the addressed register moves; acc has no path back from here
        if (hitVec[`CRLD_HIT_INT_ONE]) begin
            next_cur.regs.intCtrlRegOne = accValue;
        end
        if (hitVec[`CRLD_HIT_INT_TWO]) begin
            next_cur.regs.intCtrlRegTwo = accValue;
        end
        if (hitVec[`CRLD_HIT_TMR_ONE]) begin
            next_cur.regs.timerCtrlRegOne = accValue;
        end
        if (hitVec[`CRLD_HIT_TMR_TWO]) begin
            next_cur.regs.timerCtrlRegTwo = accValue;
        end

        // write channel capture, address and data in either order
        if (axiReq.awvalid && cur.rsp.awready) begin
            next_cur.awGot = 1'b1;
            next_cur.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && cur.rsp.wready) begin
            next_cur.wGot = 1'b1;
            next_cur.wData = axiReq.wdata;
            next_cur.wLane0 = axiReq.wstrb[0];
        end
        if (next_cur.awGot && next_cur.wGot && !cur.rsp.bvalid) begin
            doWrite = 1'b1;
        end
        if (cur.rsp.bvalid && axiReq.bready) begin
            next_cur.rsp.bvalid = 1'b0;
        end
        if (doWrite) begin
            next_cur.awGot = 1'b0;
            next_cur.wGot = 1'b0;
            next_cur.rsp.bvalid = 1'b1;
            next_cur.rsp.bresp = addrMapped(next_cur.awAddr) ? `CRLD_RESP_OKAY
                                                             : `CRLD_RESP_DECERR;
            // register images are read only; only the clear strobe acts
            if (next_cur.awAddr == `CRLD_OFS_CTRL && next_cur.wLane0 &&
                next_cur.wData[`CRLD_CTRL_CLR_BIT]) begin
                clrSeen = 1'b1;
            end
        end

        // loaded-since-clear bits and counter; a load in the clear cycle wins
        if (clrSeen) begin
            next_cur.seen = 4'h0;
            next_cur.loadCnt = `CRLD_RST_CNT;
        end
        if (|hitVec) begin
            next_cur.seen = next_cur.seen | hitVec;
            next_cur.loadCnt = clrSeen ? 8'h01 : cur.loadCnt + 8'h01;
            case (hitVec)
                4'h1: next_cur.lastLoad = 2'h0;
                4'h2: next_cur.lastLoad = 2'h1;
                4'h4: next_cur.lastLoad = 2'h2;
                4'h8: next_cur.lastLoad = 2'h3;
                default: next_cur.lastLoad = cur.lastLoad;
            endcase
        end

        // read channel, one outstanding read
        if (cur.rsp.rvalid && axiReq.rready) begin
            next_cur.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && cur.rsp.arready) begin
            doRead = 1'b1;
        end
        if (doRead) begin
            next_cur.rsp.rvalid = 1'b1;
            next_cur.rsp.rdata = readReg(axiReq.araddr, cur);
            next_cur.rsp.rresp = addrMapped(axiReq.araddr) ? `CRLD_RESP_OKAY
                                                           : `CRLD_RESP_DECERR;
        end

        // readies are registered; one transfer of each kind at a time
        next_cur.rsp.awready = !next_cur.awGot && !next_cur.rsp.bvalid;
        next_cur.rsp.wready = !next_cur.wGot && !next_cur.rsp.bvalid;
        next_cur.rsp.arready = !next_cur.rsp.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur <= '0;
            cur.regs.intCtrlRegOne <= `CRLD_RST_CTRL_REG;
            cur.regs.intCtrlRegTwo <= `CRLD_RST_CTRL_REG;
            cur.regs.timerCtrlRegOne <= `CRLD_RST_CTRL_REG;
            cur.regs.timerCtrlRegTwo <= `CRLD_RST_CTRL_REG;
            cur.loadCnt <= `CRLD_RST_CNT;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state flops
    assign axiRsp = cur.rsp;
    assign ctrlRegs = cur.regs;
    assign loadDone = cur.loadDone;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    wire execIntOne = instrExec && instrWord == `CRLD_OP_INT_ONE;
    wire execIntTwo = instrExec && instrWord == `CRLD_OP_INT_TWO;
    wire execTmrOne = instrExec && instrWord == TMR_ONE_OP;
    wire execTmrTwo = instrExec && instrWord == `CRLD_OP_TMR_TWO;

    int_one_load_a: assert property (execIntOne |=> ctrlRegs.intCtrlRegOne == $past(accValue))
        else $error("interrupt register one missed its load");
    int_one_code_a: assert property (execIntOne |=> loadDone && cur.lastLoad == 2'h0)
        else $error("word 03f not decoded as interrupt load one");
    int_two_load_a: assert property (execIntTwo |=> ctrlRegs.intCtrlRegTwo == $past(accValue))
        else $error("interrupt register two missed its load");
    int_two_code_a: assert property (execIntTwo |=> loadDone && cur.lastLoad == 2'h1)
        else $error("word 03e not decoded as interrupt load two");
    tmr_one_load_a: assert property (execTmrOne |=> ctrlRegs.timerCtrlRegOne == $past(accValue))
        else $error("timer register one missed its load");
    tmr_two_load_a: assert property (execTmrTwo |=> ctrlRegs.timerCtrlRegTwo == $past(accValue))
        else $error("timer register two missed its load");
    tmr_two_code_a: assert property (execTmrTwo |=> loadDone && cur.lastLoad == 2'h3)
        else $error("word 20f not decoded as timer load two");
    only_target_a: assert property (execIntOne |=> $stable(ctrlRegs.intCtrlRegTwo) &&
        $stable(ctrlRegs.timerCtrlRegOne) && $stable(ctrlRegs.timerCtrlRegTwo))
        else $error("a load disturbed a register it does not address");
    no_load_hold_a: assert property (!(execIntOne || execIntTwo || execTmrOne || execTmrTwo)
        |=> $stable(ctrlRegs) && !loadDone)
        else $error("control registers moved without a load");
    read_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read not answered in one cycle");
    write_answer_a: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid)
        else $error("write response dropped before it was taken");
    // the bench always offers bready, so this one is what exercises the write answer
    write_taken_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid &&
        axiRsp.wready |=> axiRsp.bvalid && !axiRsp.awready && !axiRsp.wready)
        else $error("write not answered in one cycle");
    tmr_one_code_a: assert property (execTmrOne |=> loadDone && cur.lastLoad == 2'h2)
        else $error("first timer load word not decoded");
    only_int_two_a: assert property (execIntTwo |=>
        $stable(ctrlRegs.intCtrlRegOne) && $stable(ctrlRegs.timerCtrlRegOne) &&
        $stable(ctrlRegs.timerCtrlRegTwo))
        else $error("interrupt load two disturbed another register");
    only_tmr_one_a: assert property (execTmrOne |=>
        $stable(ctrlRegs.intCtrlRegOne) && $stable(ctrlRegs.intCtrlRegTwo) &&
        $stable(ctrlRegs.timerCtrlRegTwo))
        else $error("timer load one disturbed another register");
    only_tmr_two_a: assert property (execTmrTwo |=>
        $stable(ctrlRegs.intCtrlRegOne) && $stable(ctrlRegs.intCtrlRegTwo) &&
        $stable(ctrlRegs.timerCtrlRegOne))
        else $error("timer load two disturbed another register");

    cov_int_one_c: cover property (execIntOne);
    cov_tmr_two_c: cover property (execTmrTwo ##1 execIntTwo);
    cov_clear_load_c: cover property (loadDone && axiRsp.bvalid);
    cov_unmapped_c: cover property (axiRsp.rvalid && axiRsp.rresp == `CRLD_RESP_DECERR);

endmodule : crld_ctrl_load

/* File: verilog/crld_params.svh */
// constants for the control register load decoder
`ifndef CRLD_PARAMS_SVH
`define CRLD_PARAMS_SVH

// instruction codes, 10-bit words
`define CRLD_OP_INT_ONE 10'h03f
`define CRLD_OP_INT_TWO 10'h03e
`define CRLD_OP_TMR_TWO 10'h20f
`define CRLD_OP_TMR_ONE_DEFAULT 10'h20e

// one-hot positions of the four loads
`define CRLD_HIT_INT_ONE 0
`define CRLD_HIT_INT_TWO 1
`define CRLD_HIT_TMR_ONE 2
`define CRLD_HIT_TMR_TWO 3

// register byte offsets
`define CRLD_OFS_CTRL 8'h00
`define CRLD_OFS_STATUS 8'h04
`define CRLD_OFS_INT_ONE 8'h08
`define CRLD_OFS_INT_TWO 8'h0c
`define CRLD_OFS_TMR_ONE 8'h10
`define CRLD_OFS_TMR_TWO 8'h14

// field positions
`define CRLD_CTRL_CLR_BIT 0
`define CRLD_STAT_SEEN_LSB 0
`define CRLD_STAT_CNT_LSB 4
`define CRLD_STAT_LAST_LSB 12

// reset values
`define CRLD_RST_CTRL_REG 4'h0
`define CRLD_RST_CNT 8'h00

// bus answers
`define CRLD_RESP_OKAY 2'b00
`define CRLD_RESP_DECERR 2'b11

`endif

/* File: verilog/crld_pkg.sv */
// types shared by the control register load decoder
package crld_pkg;

    // bus request from the master
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } crld_axi_req_t;

    // bus answer from the slave
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } crld_axi_rsp_t;

    // the four control registers
    typedef struct packed {
        logic [3:0] intCtrlRegOne;
        logic [3:0] intCtrlRegTwo;
        logic [3:0] timerCtrlRegOne;
        logic [3:0] timerCtrlRegTwo;
    } crld_ctrl_regs_t;

    // whole state of the top module
    typedef struct packed {
        crld_ctrl_regs_t regs;
        crld_axi_rsp_t   rsp;
        logic            awGot;
        logic            wGot;
        logic [7:0]      awAddr;
        logic [31:0]     wData;
        logic            wLane0;
        logic [3:0]      seen;
        logic [7:0]      loadCnt;
        logic [1:0]      lastLoad;
        logic            loadDone;
    } crld_state_t;

endpackage : crld_pkg

/* File: verilog/crld_decode.sv */
// opcode matcher for the four control register loads
`timescale 1ns/1ps
`include "crld_params.svh"

module crld_decode #(
    parameter logic [9:0] TMR_ONE_OP = `CRLD_OP_TMR_ONE_DEFAULT
) (
    input wire logic [9:0] instrWord, // word in execute
    input wire logic instrExec, // execute strobe
    output logic [3:0] hitVec // one-hot load select
);

    ////////////////////////////////////////////////////////////////////////
    // each pattern is a full 10-bit compare, so no other word can alias
    always_comb begin
        hitVec = 4'h0;
        if (instrExec) begin
            hitVec[`CRLD_HIT_INT_ONE] = (instrWord == `CRLD_OP_INT_ONE);
            hitVec[`CRLD_HIT_INT_TWO] = (instrWord == `CRLD_OP_INT_TWO);
            hitVec[`CRLD_HIT_TMR_ONE] = (instrWord == TMR_ONE_OP);
            hitVec[`CRLD_HIT_TMR_TWO] = (instrWord == `CRLD_OP_TMR_TWO);
        end
    end

endmodule : crld_decode

/* File: testbench/crld_ctrl_load_bench.sv */
// self-checking bench for the control register load decoder
`timescale 1ns/1ps
`include "crld_params.svh"

module crld_ctrl_load_bench
    import crld_pkg::*;
;
    logic mclk, reset, instrExec, loadDone;
    logic [9:0] instrWord;
    logic [3:0] accValue;
    crld_axi_req_t axiReq;
    crld_axi_rsp_t axiRsp;
    crld_ctrl_regs_t ctrlRegs, expRegs;
    logic [3:0] expSeen;
    logic [7:0] expCnt;
    logic [1:0] expLast;
    logic [31:0] rd;
    logic [1:0] rs;
    int miscompares, checksDone;
    // load words in status index order
    logic [9:0] ops [4] = '{`CRLD_OP_INT_ONE, `CRLD_OP_INT_TWO, `CRLD_OP_TMR_ONE_DEFAULT,
                            `CRLD_OP_TMR_TWO};
    // neighbours of the real words, one bit off each except 3ff
    logic [9:0] miss [5] = '{10'h03d, 10'h23f, 10'h20d, 10'h00f, 10'h3ff};

    crld_ctrl_load #(.TMR_ONE_OP(`CRLD_OP_TMR_ONE_DEFAULT)) dut_u (
        .mclk(mclk), .reset(reset), .instrWord(instrWord), .instrExec(instrExec),
        .accValue(accValue), .axiReq(axiReq), .axiRsp(axiRsp), .ctrlRegs(ctrlRegs),
        .loadDone(loadDone));

    // 20 MHz instruction clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare and closing tasks
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpWord

    task automatic cmpRegs(input crld_ctrl_regs_t got, input crld_ctrl_regs_t exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t regs got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpRegs

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // one executed word; the model updates before the edge, outputs checked after it
    task automatic exec(input logic [9:0] w, input logic e, input logic [3:0] a);
        int idx;
        idx = -1;
        for (int k = 0; k < 4; k++) if (e && ops[k] == w) idx = k;
        case (idx)
            0: expRegs.intCtrlRegOne = a;
            1: expRegs.intCtrlRegTwo = a;
            2: expRegs.timerCtrlRegOne = a;
            3: expRegs.timerCtrlRegTwo = a;
            default: ;
        endcase
        if (idx >= 0) begin
            expSeen[idx] = 1'b1;
            expCnt++;
            expLast = 2'(idx);
        end
        @(posedge mclk);
        instrWord <= w;
        instrExec <= e;
        accValue <= a;
        @(posedge mclk);
        instrExec <= 1'b0;
        #1;
        cmpRegs(ctrlRegs, expRegs);
        cmpWord({31'h0, loadDone}, {31'h0, idx >= 0});
    endtask : exec

    // bus write: address and data offered together, each released when taken
    task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data,
                            output logic [1:0] resp);
        logic awPend, wPend;
        awPend = 1'b1;
        wPend = 1'b1;
        @(posedge mclk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= addr;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= data;
        axiReq.wstrb <= 4'hf;
        axiReq.bready <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (awPend && axiRsp.awready === 1'b1) begin
                awPend = 1'b0;
                axiReq.awvalid <= 1'b0;
            end
            if (wPend && axiRsp.wready === 1'b1) begin
                wPend = 1'b0;
                axiReq.wvalid <= 1'b0;
            end
            if (axiRsp.bvalid === 1'b1) begin
                resp = axiRsp.bresp;
                axiReq.bready <= 1'b0;
                return;
            end
        end
        miscompares++;
        conclude();
    endtask : axiWrite

    // bus read: rready held until the data is seen
    task automatic axiRead(input logic [7:0] addr, output logic [31:0] data,
                           output logic [1:0] resp);
        logic arPend;
        arPend = 1'b1;
        @(posedge mclk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= addr;
        axiReq.rready <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (arPend && axiRsp.arready === 1'b1) begin
                arPend = 1'b0;
                axiReq.arvalid <= 1'b0;
            end
            if (axiRsp.rvalid === 1'b1) begin
                data = axiRsp.rdata;
                resp = axiRsp.rresp;
                axiReq.rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        conclude();
    endtask : axiRead

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset = 1'b1;
        instrExec = 1'b0;
        instrWord = 10'h000;
        accValue = 4'h0;
        axiReq = '0;
        expRegs = '0;
        expSeen = 4'h0;
        expCnt = 8'h00;
        expLast = 2'h0;
        miscompares = 0;
        checksDone = 0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        #1;
        cmpRegs(ctrlRegs, expRegs);
        axiRead(`CRLD_OFS_STATUS, rd, rs);
        cmpWord(rd, 32'h0);
        $display("test reset values ended");
        // every load twice, so each register is overwritten once
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) exec(ops[k], 1'b1, 4'(p * 4 + k + 3));
        end
        $display("test four loads ended");
        // near misses and a strobe-less word must leave everything alone
        foreach (miss[i]) exec(miss[i], 1'b1, 4'hf);
        exec(ops[0], 1'b0, 4'hf);
        $display("test foreign words ended");
        // two loads in adjacent cycles, timer two then interrupt two
        expRegs.timerCtrlRegTwo = 4'h2;
        expRegs.intCtrlRegTwo = 4'h6;
        expSeen = expSeen | 4'ha;
        expCnt = expCnt + 8'h02;
        expLast = 2'h1;
        @(posedge mclk);
        instrWord <= `CRLD_OP_TMR_TWO;
        instrExec <= 1'b1;
        accValue <= 4'h2;
        @(posedge mclk);
        instrWord <= `CRLD_OP_INT_TWO;
        accValue <= 4'h6;
        @(posedge mclk);
        instrExec <= 1'b0;
        #1;
        cmpRegs(ctrlRegs, expRegs);
        cmpWord({31'h0, loadDone}, 32'h1);
        $display("test adjacent loads ended");
        // registers and status seen over the bus; a write to a read-only place is ignored
        axiWrite(`CRLD_OFS_INT_ONE, 32'hf, rs);
        cmpWord({30'h0, rs}, {30'h0, `CRLD_RESP_OKAY});
        for (int k = 0; k < 4; k++) begin
            axiRead(8'(`CRLD_OFS_INT_ONE + 4 * k), rd, rs);
            cmpWord(rd, {28'h0, expRegs[15 - 4 * k -: 4]});
        end
        axiRead(`CRLD_OFS_STATUS, rd, rs);
        cmpWord(rd, {18'h0, expLast, expCnt, expSeen});
        cmpWord({30'h0, rs}, {30'h0, `CRLD_RESP_OKAY});
        // clearing keeps the last-load index
        axiWrite(`CRLD_OFS_CTRL, 32'h1, rs);
        expSeen = 4'h0;
        expCnt = 8'h00;
        axiRead(`CRLD_OFS_STATUS, rd, rs);
        cmpWord(rd, {18'h0, expLast, expCnt, expSeen});
        // a load in the very cycle of a clear survives it: seen bit set, count one
        fork
            axiWrite(`CRLD_OFS_CTRL, 32'h1, rs);
            exec(ops[2], 1'b1, 4'h9);
        join
        cmpWord({30'h0, rs}, {30'h0, `CRLD_RESP_OKAY});
        axiRead(`CRLD_OFS_STATUS, rd, rs);
        cmpWord(rd, {18'h0, expLast, expCnt, expSeen});
        // unmapped place answers with a decode error and zero data
        axiWrite(8'h18, 32'h5, rs);
        cmpWord({30'h0, rs}, {30'h0, `CRLD_RESP_DECERR});
        axiRead(8'h18, rd, rs);
        cmpWord(rd, 32'h0);
        cmpWord({30'h0, rs}, {30'h0, `CRLD_RESP_DECERR});
        $display("test bus access ended");
        conclude();
    end
endmodule : crld_ctrl_load_bench
